// [logic/i2c_regs_pkg.sv]
package i2c_regs_pkg;
  // register byte offsets
  localparam logic [7:0]  CTRL_OFF       = 8'h00;
  localparam logic [7:0]  STATUS_OFF     = 8'h18;
  localparam logic [7:0]  FLAG_CLEAR_OFF = 8'h1C;
  localparam logic [7:0]  CHECK_OFF      = 8'h20;
  localparam logic [7:0]  RX_OFF         = 8'h24;
  localparam logic [7:0]  TX_OFF         = 8'h28;
  localparam logic [7:0]  MASK_OFF       = 8'h2C;
  localparam logic [31:0] REG_RESET      = 32'h0000_0000;
  // status / flag-clear / mask bit positions
  localparam int TXE_BIT   = 0;
  localparam int ADDR_BIT  = 3;
  localparam int NACK_BIT  = 4;
  localparam int STOP_BIT  = 5;
  localparam int BERR_BIT  = 8;
  localparam int ARB_BIT   = 9;
  localparam int OVR_BIT   = 10;
  localparam int PECE_BIT  = 11;
  localparam int TTE_BIT   = 12;
  localparam int ALERT_BIT = 13;
  localparam logic [31:0] FLAG_MASK  = 32'h0000_3F38;
  localparam logic [31:0] SMBUS_MASK = 32'h0000_3800;
  // control register bit positions
  localparam int EN_BIT       = 0;
  localparam int CHECK_EN_BIT = 1;
  localparam int HOST_BIT     = 2;
  localparam int ALERT_EN_BIT = 3;
  localparam int START_BIT    = 4;
  localparam logic [31:0] CTRL_MASK = 32'h0000_001F;
  // receiver
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_SLOT      = 4'h8;
  localparam logic [7:0] CRC_POLY      = 8'h07;
  typedef enum logic {
    RX_IDLE = 1'b0,
    RX_BUSY = 1'b1
  } rx_state_t;
endpackage : i2c_regs_pkg

// [logic/i2c_flag_clear_and_data_regs.sv]
`timescale 1ns/100ps
module i2c_flag_clear_and_data_regs #(
  parameter bit SMBUS_SUPPORT = 1'b1
) (
  input  wire logic        mclk_i,
  input  wire logic        reset_n_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  input  wire logic        alert_n_i,
  input  wire logic        addr_match_ev_i,
  input  wire logic        bus_error_ev_i,
  input  wire logic        arb_lost_ev_i,
  input  wire logic        over_under_ev_i,
  input  wire logic        check_error_ev_i,
  input  wire logic        timeout_ev_i,
  input  wire logic        tx_take_i,
  output logic      [7:0]  tx_byte_o,
  output logic             tx_empty_o,
  output logic             start_request_o,
  output logic             controller_enable_o,
  output logic             check_enable_o,
  output logic             irq_o
);

  // decode shared by read and write paths
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == i2c_regs_pkg::CTRL_OFF) ||
                (a == i2c_regs_pkg::STATUS_OFF) ||
                (a == i2c_regs_pkg::FLAG_CLEAR_OFF) ||
                (a == i2c_regs_pkg::CHECK_OFF) ||
                (a == i2c_regs_pkg::RX_OFF) ||
                (a == i2c_regs_pkg::TX_OFF) ||
                (a == i2c_regs_pkg::MASK_OFF);
  endfunction : is_mapped

  // bitwise crc-8 step over one byte, msb first
  function automatic logic [7:0] crc8(input logic [7:0] c,
                                      input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ({r[6:0], 1'b0} ^ i2c_regs_pkg::CRC_POLY)
               : {r[6:0], 1'b0};
    end
    crc8 = r;
  endfunction : crc8

  logic [31:0] ctrl_q;
  logic [31:0] mask_q;
  logic [31:0] flags_q;
  logic [31:0] flags_d;
  logic [31:0] set_ev;
  logic [31:0] clr_ev;
  logic [31:0] smbus_keep;
  logic [7:0]  pec_q;
  logic [7:0]  rx_q;
  logic [7:0]  tx_q;
  logic        txe_q;
  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] prdata_q;
  logic        irq_q;
  logic        wr_acc;
  logic        en;
  logic        check_en;

  assign en       = ctrl_q[i2c_regs_pkg::EN_BIT];
  assign check_en = ctrl_q[i2c_regs_pkg::CHECK_EN_BIT];
  assign wr_acc   = psel_i && penable_i && pwrite_i && pready_q;
  assign smbus_keep = SMBUS_SUPPORT ? 32'hFFFF_FFFF
                                    : ~i2c_regs_pkg::SMBUS_MASK;

  // pin synchronisers: three stages, change accepted when 2nd and 3rd agree
  logic [2:0] scl_s;
  logic [2:0] sda_s;
  logic [2:0] alt_s;
  logic       scl_f;
  logic       sda_f;
  logic       alt_f;
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
      alt_s <= 3'h7;
    end else begin
      scl_s <= {scl_s[1:0], scl_i};
      sda_s <= {sda_s[1:0], sda_i};
      alt_s <= {alt_s[1:0], alert_n_i};
    end
  end

  // filtered levels; bus idles high
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      scl_f <= 1'b1;
      sda_f <= 1'b1;
      alt_f <= 1'b1;
    end else begin
      if (scl_s[1] == scl_s[2]) scl_f <= scl_s[2];
      if (sda_s[1] == sda_s[2]) sda_f <= sda_s[2];
      if (alt_s[1] == alt_s[2]) alt_f <= alt_s[2];
    end
  end

  logic scl_rise;
  logic start_cond;
  logic stop_cond;
  logic alert_fall;
  assign scl_rise   = (scl_s[1] == scl_s[2]) && scl_s[2] && !scl_f;
  assign start_cond = scl_f && (sda_s[1] == sda_s[2]) && !sda_s[2] && sda_f;
  assign stop_cond  = scl_f && (sda_s[1] == sda_s[2]) && sda_s[2] && !sda_f;
  assign alert_fall = (alt_s[1] == alt_s[2]) && !alt_s[2] && alt_f;

  // byte receiver: sample on scl rise, ninth slot is the acknowledge
  i2c_regs_pkg::rx_state_t rx_state_q;
  logic [3:0] bit_cnt_q;
  logic [6:0] shift_q;
  logic       byte_done;
  logic       nack_ev;
  logic [7:0] byte_in;
  assign byte_in   = {shift_q, sda_f};
  assign byte_done = (rx_state_q == i2c_regs_pkg::RX_BUSY) && scl_rise &&
                     (bit_cnt_q == i2c_regs_pkg::LAST_DATA_BIT);
  assign nack_ev   = (rx_state_q == i2c_regs_pkg::RX_BUSY) && scl_rise &&
                     (bit_cnt_q == i2c_regs_pkg::ACK_SLOT) && sda_f;

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rx_state_q <= i2c_regs_pkg::RX_IDLE;
      bit_cnt_q  <= 4'h0;
      shift_q    <= 7'h00;
    end else if (!en) begin
      rx_state_q <= i2c_regs_pkg::RX_IDLE;
      bit_cnt_q  <= 4'h0;
    end else begin
      unique case (rx_state_q)
        i2c_regs_pkg::RX_IDLE: begin
          if (start_cond) begin
            rx_state_q <= i2c_regs_pkg::RX_BUSY;
            bit_cnt_q  <= 4'h0;
          end
        end
        i2c_regs_pkg::RX_BUSY: begin
          if (stop_cond) begin
            rx_state_q <= i2c_regs_pkg::RX_IDLE;
          end else if (start_cond) begin
            bit_cnt_q <= 4'h0; // repeated start
          end else if (scl_rise) begin
            shift_q   <= byte_in[6:0];
            bit_cnt_q <= (bit_cnt_q == i2c_regs_pkg::ACK_SLOT) ? 4'h0
                         : bit_cnt_q + 4'h1;
          end
        end
      endcase
    end
  end

  // latest received byte
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) rx_q <= 8'h00;
    else if (byte_done) rx_q <= byte_in;
  end

  // running check byte; cleared while disabled
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) pec_q <= 8'h00;
    else if (!en) pec_q <= 8'h00;
    else if (byte_done && check_en) pec_q <= crc8(pec_q, byte_in);
  end

  // flag events and write-one clears; a set in the same cycle wins
  always_comb begin
    set_ev = 32'h0000_0000;
    set_ev[i2c_regs_pkg::ADDR_BIT]  = addr_match_ev_i;
    set_ev[i2c_regs_pkg::NACK_BIT]  = nack_ev;
    set_ev[i2c_regs_pkg::STOP_BIT]  = en && stop_cond;
    set_ev[i2c_regs_pkg::BERR_BIT]  = bus_error_ev_i;
    set_ev[i2c_regs_pkg::ARB_BIT]   = arb_lost_ev_i;
    set_ev[i2c_regs_pkg::OVR_BIT]   = over_under_ev_i;
    set_ev[i2c_regs_pkg::PECE_BIT]  = check_error_ev_i;
    set_ev[i2c_regs_pkg::TTE_BIT]   = timeout_ev_i;
    set_ev[i2c_regs_pkg::ALERT_BIT] = en && alert_fall &&
                                      ctrl_q[i2c_regs_pkg::HOST_BIT] &&
                                      ctrl_q[i2c_regs_pkg::ALERT_EN_BIT];
    clr_ev = 32'h0000_0000;
    if (wr_acc && paddr_i == i2c_regs_pkg::FLAG_CLEAR_OFF) begin
      clr_ev = pwdata_i & i2c_regs_pkg::FLAG_MASK;
    end
    if (!en) begin
      clr_ev[i2c_regs_pkg::ALERT_BIT] = 1'b1;
    end
    flags_d = ((flags_q & ~clr_ev) | set_ev) & i2c_regs_pkg::FLAG_MASK;
    flags_d = flags_d & smbus_keep;
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) flags_q <= i2c_regs_pkg::REG_RESET;
    else flags_q <= flags_d;
  end

  // control: software sets fields, address-match clear drops start request
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_q <= i2c_regs_pkg::REG_RESET;
    end else if (wr_acc && paddr_i == i2c_regs_pkg::CTRL_OFF) begin
      ctrl_q <= pwdata_i & i2c_regs_pkg::CTRL_MASK;
    end else if (wr_acc && paddr_i == i2c_regs_pkg::FLAG_CLEAR_OFF &&
                 pwdata_i[i2c_regs_pkg::ADDR_BIT]) begin
      ctrl_q[i2c_regs_pkg::START_BIT] <= 1'b0;
    end
  end

  // interrupt mask, same layout as status
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) mask_q <= i2c_regs_pkg::REG_RESET;
    else if (wr_acc && paddr_i == i2c_regs_pkg::MASK_OFF) begin
      mask_q <= pwdata_i & i2c_regs_pkg::FLAG_MASK & smbus_keep;
    end
  end

  // transmit byte; a write while full is dropped so no queued byte is lost
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tx_q  <= 8'h00;
      txe_q <= 1'b1;
    end else if (wr_acc && paddr_i == i2c_regs_pkg::TX_OFF && txe_q) begin
      tx_q  <= pwdata_i[7:0];
      txe_q <= 1'b0;
    end else if (tx_take_i || !en) begin
      txe_q <= 1'b1;
    end
  end

  // apb: zero-wait answer, ready raised in the access phase
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= psel_i && !penable_i && !pready_q;
      pslverr_q <= psel_i && !penable_i && !pready_q && !is_mapped(paddr_i);
    end
  end

  // read data captured in the setup cycle
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      unique case (paddr_i)
        i2c_regs_pkg::CTRL_OFF:   prdata_q <= ctrl_q;
        i2c_regs_pkg::STATUS_OFF: begin
          prdata_q <= flags_q;
          prdata_q[i2c_regs_pkg::TXE_BIT] <= txe_q;
        end
        i2c_regs_pkg::CHECK_OFF:
          prdata_q <= {24'h000000, check_en ? pec_q : 8'h00};
        i2c_regs_pkg::RX_OFF:     prdata_q <= {24'h000000, rx_q};
        i2c_regs_pkg::TX_OFF:     prdata_q <= {24'h000000, tx_q};
        i2c_regs_pkg::MASK_OFF:   prdata_q <= mask_q;
        default:                  prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // level interrupt, one cycle behind the flags
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) irq_q <= 1'b0;
    else irq_q <= |(flags_q & mask_q);
  end

  assign prdata_o            = prdata_q;
  assign pready_o            = pready_q;
  assign pslverr_o           = pslverr_q;
  assign tx_byte_o           = tx_q;
  assign tx_empty_o          = txe_q;
  assign start_request_o     = ctrl_q[i2c_regs_pkg::START_BIT];
  assign controller_enable_o = ctrl_q[i2c_regs_pkg::EN_BIT];
  assign check_enable_o      = ctrl_q[i2c_regs_pkg::CHECK_EN_BIT];
  assign irq_o               = irq_q;

  // checks
  logic fc_wr;
  assign fc_wr = wr_acc && paddr_i == i2c_regs_pkg::FLAG_CLEAR_OFF;

  sequence s_setup;
    psel_i && !penable_i && !pready_q;
  endsequence
  sequence s_answer;
    pready_q ##1 !pready_q;
  endsequence

  property p_apb_answer;
    @(posedge mclk_i) disable iff (!reset_n_i) s_setup |=> s_answer;
  endproperty
  a_apb_answer: assert property (p_apb_answer)
    else $error("apb answer not in one cycle");

  property p_addr_clear;
    @(posedge mclk_i) disable iff (!reset_n_i)
      fc_wr && pwdata_i[3] && !addr_match_ev_i && ctrl_q[4] |=>
      !flags_q[3] && !ctrl_q[4];
  endproperty
  a_addr_clear: assert property (p_addr_clear)
    else $error("address match clear failed");

  property p_nack_clear;
    @(posedge mclk_i) disable iff (!reset_n_i)
      fc_wr && pwdata_i[4] && !nack_ev |=> !flags_q[4];
  endproperty
  a_nack_clear: assert property (p_nack_clear)
    else $error("nack clear failed");

  property p_stop_clear;
    @(posedge mclk_i) disable iff (!reset_n_i)
      fc_wr && pwdata_i[5] && !set_ev[5] |=> !flags_q[5];
  endproperty
  a_stop_clear: assert property (p_stop_clear)
    else $error("stop clear failed");

  property p_err_clear;
    @(posedge mclk_i) disable iff (!reset_n_i)
      fc_wr && (pwdata_i[10:8] != 3'h0) &&
      !bus_error_ev_i && !arb_lost_ev_i && !over_under_ev_i
      |=> (flags_q[10:8] & $past(pwdata_i[10:8])) == 3'h0;
  endproperty
  a_err_clear: assert property (p_err_clear)
    else $error("error flag clear failed");

  property p_smbus_clear;
    @(posedge mclk_i) disable iff (!reset_n_i)
      fc_wr && (pwdata_i[13:11] != 3'h0) && (set_ev[13:11] == 3'h0)
      |=> (flags_q[13:11] & $past(pwdata_i[13:11])) == 3'h0;
  endproperty
  a_smbus_clear: assert property (p_smbus_clear)
    else $error("smbus flag clear failed");

  property p_no_smbus;
    @(posedge mclk_i) disable iff (!reset_n_i)
      !SMBUS_SUPPORT |-> flags_q[13:11] == 3'h0 && mask_q[13:11] == 3'h0;
  endproperty
  a_no_smbus: assert property (p_no_smbus)
    else $error("reserved smbus bits set");

  property p_pec_zero;
    @(posedge mclk_i) disable iff (!reset_n_i) !en |=> pec_q == 8'h00;
  endproperty
  a_pec_zero: assert property (p_pec_zero)
    else $error("check byte not cleared");

  property p_pec_step;
    @(posedge mclk_i) disable iff (!reset_n_i)
      byte_done && en && check_en |=> pec_q == crc8($past(pec_q),
                                                    $past(byte_in));
  endproperty
  a_pec_step: assert property (p_pec_step)
    else $error("check byte not updated");

  property p_rx_byte;
    @(posedge mclk_i) disable iff (!reset_n_i)
      byte_done |=> rx_q == $past(byte_in) ##1 $stable(rx_q) || byte_done;
  endproperty
  a_rx_byte: assert property (p_rx_byte)
    else $error("received byte not held");

  property p_tx_guard;
    @(posedge mclk_i) disable iff (!reset_n_i)
      wr_acc && paddr_i == i2c_regs_pkg::TX_OFF && !txe_q |=> $stable(tx_q);
  endproperty
  a_tx_guard: assert property (p_tx_guard)
    else $error("transmit byte overwritten while full");

  property p_zero_keeps;
    @(posedge mclk_i) disable iff (!reset_n_i)
      fc_wr && flags_q[8] && !pwdata_i[8] |=> flags_q[8];
  endproperty
  a_zero_keeps: assert property (p_zero_keeps)
    else $error("zero write cleared a flag");

  property p_alert_off;
    @(posedge mclk_i) disable iff (!reset_n_i) !en |=> !flags_q[13];
  endproperty
  a_alert_off: assert property (p_alert_off)
    else $error("alert flag kept while disabled");

endmodule : i2c_flag_clear_and_data_regs

// [bench/i2c_bus_model.sv]
`timescale 1ns/100ps
// far-side bus master: drives scl/sda and the alert pin, all pulled up
module i2c_bus_model (
  output logic scl_o,
  output logic sda_o,
  output logic alert_n_o
);
  // released lines float to their pull-up level; scl stands still when idle
  initial begin
    scl_o     = 1'b1;
    sda_o     = 1'b1;
    alert_n_o = 1'b1;
  end

  // one byte with start, ack slot and stop; link period 320 ns
  task automatic frame(input logic [7:0] b, input logic ack_hi);
    #7 sda_o = 1'b0;
    #160 scl_o = 1'b0;
    for (int i = 0; i < 9; i++) begin
      #80 sda_o = (i < 8) ? b[7-i] : ack_hi; // msb first, then ack slot
      #80 scl_o = 1'b1;
      #160 scl_o = 1'b0;
    end
    #80 sda_o = 1'b0;
    #80 scl_o = 1'b1;
    #160 sda_o = 1'b1;
    #160;
  endtask : frame

  // alert pin pulled low for a while, then released
  task automatic alert();
    #13 alert_n_o = 1'b0;
    #400 alert_n_o = 1'b1;
  endtask : alert
endmodule : i2c_bus_model

// [bench/tb_top.sv]
`timescale 1ns/100ps
module tb_top;
  logic        mclk_i     = 1'b0;
  logic        reset_n_i  = 1'b0;
  logic        psel_q     = 1'b0;
  logic        penable_q  = 1'b0;
  logic        pwrite_q   = 1'b0;
  logic [7:0]  paddr_q    = 8'h00;
  logic [31:0] pwdata_q   = 32'h0000_0000;
  logic [5:0]  ev_q       = 6'h00;
  logic        tx_take_q  = 1'b0;
  logic [31:0] prdata_o;
  logic        pready_o, pslverr_o, scl, sda, alert_n;
  logic [7:0]  tx_byte_o;
  logic        tx_empty_o, start_request_o, irq_o;
  logic        controller_enable_o, check_enable_o;
  logic [31:0] rd;
  logic        er;
  int          error_cnt = 0;
  int          samples_checked = 0;

  i2c_bus_model u_bus (.scl_o(scl), .sda_o(sda), .alert_n_o(alert_n));

  i2c_flag_clear_and_data_regs dut (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .psel_i(psel_q),
    .penable_i(penable_q), .pwrite_i(pwrite_q), .paddr_i(paddr_q),
    .pwdata_i(pwdata_q), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .scl_i(scl), .sda_i(sda), .alert_n_i(alert_n),
    .addr_match_ev_i(ev_q[0]), .bus_error_ev_i(ev_q[1]),
    .arb_lost_ev_i(ev_q[2]), .over_under_ev_i(ev_q[3]),
    .check_error_ev_i(ev_q[4]), .timeout_ev_i(ev_q[5]),
    .tx_take_i(tx_take_q), .tx_byte_o(tx_byte_o), .tx_empty_o(tx_empty_o),
    .start_request_o(start_request_o),
    .controller_enable_o(controller_enable_o),
    .check_enable_o(check_enable_o), .irq_o(irq_o));

  // clock; reset held for 8 cycles
  initial begin
    forever #20 mclk_i = ~mclk_i;
  end

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize

  // apb access; request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk_i);
    psel_q    <= 1'b1;
    penable_q <= 1'b0;
    pwrite_q  <= w;
    paddr_q   <= a;
    pwdata_q  <= d;
    @(posedge mclk_i);
    penable_q <= 1'b1;
    // the edge that sees pready high is the one that completes the access
    do begin
      @(posedge mclk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    if (n >= 50) check("pready", 32'h0, 32'h1);
    rd = prdata_o;
    er = pslverr_o;
    psel_q    <= 1'b0;
    penable_q <= 1'b0;
  endtask : apb

  task automatic rd_chk(input string name, input logic [7:0] a,
                        input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(name, rd, exp);
  endtask : rd_chk

  // crc-8, poly 0x07, init 0, msb first
  function automatic logic [7:0] crc8(input logic [7:0] b);
    logic [7:0] c;
    c = b;
    for (int i = 0; i < 8; i++) c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : c << 1;
    return c;
  endfunction : crc8

  task automatic t_reset_map();
    rd_chk("clear", i2c_regs_pkg::FLAG_CLEAR_OFF, 32'h0);
    rd_chk("check", i2c_regs_pkg::CHECK_OFF, 32'h0);
    rd_chk("rx", i2c_regs_pkg::RX_OFF, 32'h0);
    rd_chk("tx", i2c_regs_pkg::TX_OFF, 32'h0);
    rd_chk("unmapped", 8'h30, 32'h0);
    check("slverr", {31'h0, er}, 32'h1);
  endtask : t_reset_map

  // every engine event: set, survive a zero write, then write-one clear
  task automatic t_flags();
    int b;
    int fb[6] = '{3, 8, 9, 10, 11, 12};
    apb(1'b1, i2c_regs_pkg::MASK_OFF, i2c_regs_pkg::FLAG_MASK);
    for (int i = 0; i < 6; i++) begin
      b = fb[i];
      apb(1'b1, i2c_regs_pkg::CTRL_OFF, 32'h0000_0011);
      @(posedge mclk_i) ev_q <= 6'h01 << i;
      @(posedge mclk_i) ev_q <= 6'h00;
      apb(1'b1, i2c_regs_pkg::FLAG_CLEAR_OFF, 32'h0);
      apb(1'b0, i2c_regs_pkg::STATUS_OFF, 32'h0);
      check("flag kept", rd[b], 1'b1);
      check("irq set", irq_o, 1'b1);
      apb(1'b1, i2c_regs_pkg::FLAG_CLEAR_OFF, 32'h1 << b);
      apb(1'b0, i2c_regs_pkg::STATUS_OFF, 32'h0);
      check("flag cleared", rd[13:3], 32'h0);
      check("start req", start_request_o, i == 0 ? 1'b0 : 1'b1);
      check("irq clear", irq_o, 1'b0);
    end
    rd_chk("clear reads", i2c_regs_pkg::FLAG_CLEAR_OFF, 32'h0);
  endtask : t_flags

  // one received byte with nack and stop; check byte and disable
  task automatic t_rx();
    apb(1'b1, i2c_regs_pkg::CTRL_OFF, 32'h0000_0003);
    u_bus.frame(8'hA5, 1'b1);
    repeat (10) @(posedge mclk_i);
    check("enable out", controller_enable_o, 1'b1);
    check("check enable out", check_enable_o, 1'b1);
    rd_chk("rx byte", i2c_regs_pkg::RX_OFF, 32'h0000_00A5);
    rd_chk("check byte", i2c_regs_pkg::CHECK_OFF, {24'h0, crc8(8'hA5)});
    apb(1'b0, i2c_regs_pkg::STATUS_OFF, 32'h0);
    check("nack stop", rd & 32'h0000_0030, 32'h0000_0030);
    apb(1'b1, i2c_regs_pkg::FLAG_CLEAR_OFF, 32'h0000_0010);
    apb(1'b0, i2c_regs_pkg::STATUS_OFF, 32'h0);
    check("nack clr", rd & 32'h0000_0030, 32'h0000_0020);
    apb(1'b1, i2c_regs_pkg::FLAG_CLEAR_OFF, 32'h0000_0020);
    apb(1'b0, i2c_regs_pkg::STATUS_OFF, 32'h0);
    check("stop clr", rd & 32'h0000_0030, 32'h0);
    apb(1'b1, i2c_regs_pkg::CTRL_OFF, 32'h0);
    rd_chk("check off", i2c_regs_pkg::CHECK_OFF, 32'h0);
    check("enable off", controller_enable_o, 1'b0);
    check("check enable off", check_enable_o, 1'b0);
    // re-enable: the value must have been wiped, not merely hidden
    apb(1'b1, i2c_regs_pkg::CTRL_OFF, 32'h0000_0003);
    rd_chk("check wiped", i2c_regs_pkg::CHECK_OFF, 32'h0);
  endtask : t_rx

  // alert edge sets the flag; write-one and disable each clear it
  task automatic t_alert();
    apb(1'b1, i2c_regs_pkg::CTRL_OFF, 32'h0000_000D);
    for (int k = 0; k < 2; k++) begin
      u_bus.alert();
      repeat (8) @(posedge mclk_i);
      apb(1'b0, i2c_regs_pkg::STATUS_OFF, 32'h0);
      check("alert set", rd[13], 1'b1);
      if (k == 0) apb(1'b1, i2c_regs_pkg::FLAG_CLEAR_OFF, 32'h0000_2000);
      else apb(1'b1, i2c_regs_pkg::CTRL_OFF, 32'h0);
      apb(1'b0, i2c_regs_pkg::STATUS_OFF, 32'h0);
      check("alert gone", rd[13], 1'b0);
    end
  endtask : t_alert

  // transmit byte only accepted while the buffer is empty
  task automatic t_tx();
    // disabled controller keeps the buffer empty, so enable first
    apb(1'b1, i2c_regs_pkg::CTRL_OFF, 32'h0000_0001);
    apb(1'b1, i2c_regs_pkg::TX_OFF, 32'h0000_005A);
    @(negedge mclk_i);
    check("tx empty", tx_empty_o, 1'b0);
    check("tx out", tx_byte_o, 8'h5A);
    apb(1'b1, i2c_regs_pkg::TX_OFF, 32'h0000_0033);
    rd_chk("tx kept", i2c_regs_pkg::TX_OFF, 32'h0000_005A);
    @(posedge mclk_i) tx_take_q <= 1'b1;
    @(posedge mclk_i) tx_take_q <= 1'b0;
    @(negedge mclk_i);
    check("tx refill", tx_empty_o, 1'b1);
    apb(1'b1, i2c_regs_pkg::TX_OFF, 32'h0000_0033);
    rd_chk("tx new", i2c_regs_pkg::TX_OFF, 32'h0000_0033);
  endtask : t_tx

  initial begin
    repeat (8) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    t_reset_map();
    t_flags();
    t_rx();
    t_alert();
    t_tx();
    summarize();
  end

  // watchdog well beyond the expected run length
  initial begin
    #2000000;
    error_cnt++;
    summarize();
  end
endmodule : tb_top
